// ==== core/stream_output_state_decode.sv ====
// stream output state decoder: parses the two state packets and judges each primitive
// assumes one clock, command dwords and primitives arrive over so_link_if
`timescale 1ns/1ns
`include "so_decode_params.svh"
module stream_output_state_decode #(
    parameter int ADDR_W = 32,
    parameter int PITCH_W = 12,
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // command and primitive link
    so_link_if.decoder link,
    // buffer address state
    input wire logic [3:0][ADDR_W-1:0] buf_wr_offset_i,
    input wire logic [3:0][PITCH_W-1:0] buf_pitch_i,
    input wire logic [3:0][ADDR_W-1:0] buf_end_i,
    // declaration read port
    input wire so_decode_pkg::stream_id_t decl_rd_stream_i,
    input wire logic [`IDX_W-1:0] decl_rd_index_i,
    output so_decode_pkg::decl_t decl_rd_data_o,
    output logic decl_rd_valid_o,
    // per primitive results
    output logic render_fwd_o,
    output so_decode_pkg::stream_id_t render_stream_o,
    output logic so_write_o,
    output logic so_overflow_o,
    output so_decode_pkg::buf_mask_t so_target_o,
    output logic [5:0] so_order_o,
    output logic so_read_offset_o,
    output logic [5:0] so_read_units_o,
    // statistics
    output logic [3:0][CNT_W-1:0] prims_written_o,
    output logic [3:0][CNT_W-1:0] storage_needed_o
);
    import so_decode_pkg::*;

    dec_state_t state;
    dec_state_t next_state;
    logic [8:0] left;
    logic [8:0] pos;
    logic cmd_ready_q;
    logic commit_ctrl_q;
    logic commit_decl_q;
    // shadow copies filled while a packet streams in
    logic [31:0] sh_ctrl;
    logic [3:0][7:0] sh_size;
    logic [3:0][3:0] sh_mask;
    logic [3:0][7:0] sh_cnt;
    // state in use by the primitive logic
    logic [31:0] ctrl_q;
    logic [3:0][7:0] size_q;
    logic [3:0][3:0] mask_q;
    logic [3:0][7:0] cnt_q;
    decl_t decl_mem [0:3][0:`DECL_SLOTS-1];

    // command parsing
    wire take = link.cmd_valid && cmd_ready_q;
    wire [15:0] hdr_opc = link.cmd_data[`HDR_OPC_HI:`HDR_OPC_LO];
    wire hdr_is_decl = (hdr_opc == `OPC_DECL);
    wire [8:0] hdr_len = hdr_is_decl ? link.cmd_data[`LEN9_HI:0] : {1'b0, link.cmd_data[`LEN8_HI:0]};
    wire in_packet = (state != st_idle);
    wire last_dw = in_packet && (left == 9'h001);
    wire [8:0] body_idx = pos - `POS_BODY;
    wire [`IDX_W-1:0] grp = body_idx[7:1];
    wire half = body_idx[0];
    wire body_wr = take && (state == st_decl) && (pos >= `POS_BODY) && !body_idx[8];
    wire wr_ctrl1 = take && (state == st_ctrl) && (pos == `POS_DW1);
    wire wr_ctrl2 = take && (state == st_ctrl) && (pos == `POS_DW2);
    wire wr_decl1 = take && (state == st_decl) && (pos == `POS_DW1);
    wire wr_decl2 = take && (state == st_decl) && (pos == `POS_DW2);

    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (take) begin
                    if (hdr_opc == `OPC_CTRL) begin
                        next_state = st_ctrl;
                    end else if (hdr_is_decl) begin
                        next_state = st_decl;
                    end else begin
                        next_state = st_skip;
                    end
                end
            end
            default: begin
                if (take && last_dw) begin
                    next_state = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= st_idle;
            left <= 9'h000;
            pos <= `POS_HDR;
            cmd_ready_q <= 1'b0;
        end else begin
            state <= next_state;
            cmd_ready_q <= 1'b1;
            if (take && !in_packet) begin
                left <= hdr_len + 9'h001;
                pos <= `POS_DW1;
            end else if (take) begin
                left <= left - 9'h001;
                pos <= pos + 9'h001;
            end
        end
    end
    assign link.cmd_ready = cmd_ready_q;

    // shadow fill; dwords are kept whole, only the mask dword is cut to its low 16 bits
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sh_ctrl <= 32'h0000_0000;
            sh_size <= 32'h0000_0000;
            sh_mask <= 16'h0000;
            sh_cnt <= 32'h0000_0000;
            commit_ctrl_q <= 1'b0;
            commit_decl_q <= 1'b0;
        end else begin
            if (wr_ctrl1) begin
                sh_ctrl <= link.cmd_data;
            end
            if (wr_ctrl2) begin
                sh_size <= link.cmd_data;
            end
            if (wr_decl1) begin
                sh_mask <= link.cmd_data[15:0];
            end
            if (wr_decl2) begin
                sh_cnt <= link.cmd_data;
            end
            commit_ctrl_q <= take && last_dw && (state == st_ctrl);
            commit_decl_q <= take && last_dw && (state == st_decl);
        end
    end

    // new state applies two cycles after the packet's last dword
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= 32'h0000_0000;
            size_q <= 32'h0000_0000;
            mask_q <= 16'h0000;
            cnt_q <= 32'h0000_0000;
        end else begin
            if (commit_ctrl_q) begin
                ctrl_q <= sh_ctrl;
                size_q <= sh_size;
            end
            if (commit_decl_q) begin
                mask_q <= sh_mask;
                cnt_q <= sh_cnt;
            end
        end
    end

    // first dword of a group holds streams 0 and 1, second streams 2 and 3
    always_ff @(posedge clk_i) begin
        if (body_wr) begin
            decl_mem[{half, 1'b0}][grp] <= link.cmd_data[15:0];
            decl_mem[{half, 1'b1}][grp] <= link.cmd_data[31:16];
        end
    end

    wire rd_in_range = ({1'b0, decl_rd_index_i} < cnt_q[decl_rd_stream_i]);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            decl_rd_valid_o <= 1'b0;
            decl_rd_data_o <= 16'h0000;
        end else begin
            decl_rd_valid_o <= rd_in_range;
            decl_rd_data_o <= rd_in_range ? decl_mem[decl_rd_stream_i][decl_rd_index_i] : 16'h0000;
        end
    end

    // primitive judgement
    wire [1:0] ps = link.prim_stream;
    wire so_en = ctrl_q[`SO_EN_BIT];
    wire [3:0] buf_en = so_en ? ctrl_q[`BUFEN_HI:`BUFEN_LO] : 4'h0;
    wire [3:0] sel = mask_q[ps];
    wire so_active = so_en && (cnt_q[ps] != 8'h00);
    wire hit_disabled = |(sel & ~buf_en);
    wire [3:0] over;
    for (genvar b = 0; b < 4; b++) begin : g_room
        wire [ADDR_W:0] need = {1'b0, buf_wr_offset_i[b]}
            + (ADDR_W+1)'(link.prim_vcount * buf_pitch_i[b]);
        assign over[b] = need > {1'b0, buf_end_i[b]};
    end
    wire room_fail = |(sel & over);
    wire ovf = so_active && (hit_disabled || room_fail);
    wire do_write = so_active && !ovf;
    wire fwd = !ctrl_q[`RDIS_BIT] && (ps == ctrl_q[`RSEL_HI:`RSEL_LO]);
    wire odd_strip = link.prim_strip && link.prim_odd;
    wire [5:0] next_order = !odd_strip ? `ORDER_NORM
        : (ctrl_q[`REORD_BIT] ? `ORDER_TRAIL : `ORDER_LEAD);
    wire [4:0] rlen = size_q[ps][`RLEN_HI:`RLEN_LO];
    wire count_en = link.prim_valid && ctrl_q[`STAT_BIT];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            render_fwd_o <= 1'b0;
            render_stream_o <= 2'h0;
            so_write_o <= 1'b0;
            so_overflow_o <= 1'b0;
            so_target_o <= 4'h0;
            so_order_o <= `ORDER_NORM;
            so_read_offset_o <= 1'b0;
            so_read_units_o <= 6'h00;
        end else begin
            render_fwd_o <= link.prim_valid && fwd;
            render_stream_o <= ps;
            so_write_o <= link.prim_valid && do_write;
            so_overflow_o <= link.prim_valid && ovf;
            so_target_o <= (link.prim_valid && do_write) ? sel : 4'h0;
            so_order_o <= next_order;
            so_read_offset_o <= size_q[ps][`ROFS_BIT];
            so_read_units_o <= {1'b0, rlen} + 6'h01;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prims_written_o <= '0;
            storage_needed_o <= '0;
        end else begin
            for (int s = 0; s < 4; s++) begin
                if (count_en && (ps == 2'(s)) && so_active) begin
                    storage_needed_o[s] <= storage_needed_o[s] + 1'b1;
                end
                if (count_en && (ps == 2'(s)) && do_write) begin
                    prims_written_o[s] <= prims_written_o[s] + 1'b1;
                end
            end
        end
    end
endmodule : stream_output_state_decode

// ==== inc/so_decode_params.svh ====
// constants shared by the stream output state decoder and its command streamer
// assumes it is included by bare name from inc/
`ifndef SO_DECODE_PARAMS_SVH
`define SO_DECODE_PARAMS_SVH

// header word fields
`define HDR_OPC_HI 31
`define HDR_OPC_LO 16
`define LEN8_HI 7
`define LEN9_HI 8
`define OPC_CTRL 16'h781e
`define OPC_DECL 16'h7917
`define CTRL_LEN 8'h01
`define DECL_LEN 9'h101

// dword positions inside a packet
`define POS_HDR 9'h000
`define POS_DW1 9'h001
`define POS_DW2 9'h002
`define POS_BODY 9'h003
`define CTRL_LAST 9'h002
`define DECL_LAST 9'h102

// output control packet, dword 1
`define SO_EN_BIT 31
`define RDIS_BIT 30
`define RSEL_HI 28
`define RSEL_LO 27
`define REORD_BIT 26
`define STAT_BIT 25
`define BUFEN_HI 11
`define BUFEN_LO 8

// output control packet, dword 2, per stream byte
`define ROFS_BIT 5
`define RLEN_HI 4
`define RLEN_LO 0

// declarations
`define DECL_SLOTS 128
`define DECL_W 16
`define IDX_W 7

// vertex slot order {v2,v1,v0}, two bits each
`define ORDER_NORM 6'h24
`define ORDER_LEAD 6'h18
`define ORDER_TRAIL 6'h21
`define VCNT_W 2

`endif

// ==== inc/so_decode_pkg.sv ====
// types shared by the stream output state decoder and its command streamer
// assumes nothing beyond a SystemVerilog compiler
package so_decode_pkg;
    typedef logic [1:0] stream_id_t;
    typedef logic [3:0] buf_mask_t;
    typedef logic [15:0] decl_t;
    typedef enum logic [1:0] {st_idle, st_ctrl, st_decl, st_skip} dec_state_t;
    typedef enum logic {hs_idle, hs_send} host_state_t;
endpackage : so_decode_pkg

// ==== inc/so_link_if.sv ====
// link between the command streamer / geometry stage and the decoder
// assumes both ends share clk_i and arst_n_i
`timescale 1ns/1ns
`include "so_decode_params.svh"
interface so_link_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [31:0] cmd_data;
    logic prim_valid;
    logic [1:0] prim_stream;
    logic prim_strip;
    logic prim_odd;
    logic [`VCNT_W-1:0] prim_vcount;

    modport streamer (
        output cmd_valid, cmd_data, prim_valid, prim_stream, prim_strip, prim_odd, prim_vcount,
        input cmd_ready
    );
    modport decoder (
        input cmd_valid, cmd_data, prim_valid, prim_stream, prim_strip, prim_odd, prim_vcount,
        output cmd_ready
    );
endinterface : so_link_if

// ==== core/so_command_streamer.sv ====
// command streamer end: builds both state packets and forwards primitives
// assumes one clock shared with the decoder, link joined by the testbench
`timescale 1ns/1ns
`include "so_decode_params.svh"
module so_command_streamer (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // link to the decoder
    so_link_if.streamer link,
    // output control packet request
    input wire logic send_ctrl_i,
    input wire logic so_enable_i,
    input wire logic render_disable_i,
    input wire so_decode_pkg::stream_id_t render_stream_i,
    input wire logic reorder_trailing_i,
    input wire logic stats_enable_i,
    input wire so_decode_pkg::buf_mask_t buf_enable_i,
    input wire logic [3:0] read_offset_i,
    input wire logic [3:0][4:0] read_len_i,
    input wire logic gs_enable_i,
    input wire logic gs_vsize_zero_i,
    // declaration table and packet request
    input wire logic decl_wr_i,
    input wire so_decode_pkg::stream_id_t decl_wr_stream_i,
    input wire logic [`IDX_W-1:0] decl_wr_index_i,
    input wire so_decode_pkg::decl_t decl_wr_data_i,
    input wire logic send_decl_i,
    input wire logic [3:0][3:0] target_mask_i,
    input wire logic [3:0][7:0] num_entries_i,
    // primitives from the geometry stage
    input wire logic prim_valid_i,
    input wire so_decode_pkg::stream_id_t prim_stream_i,
    input wire logic prim_strip_i,
    input wire logic prim_odd_i,
    input wire logic [`VCNT_W-1:0] prim_vcount_i,
    // status
    output logic busy_o
);
    import so_decode_pkg::*;

    host_state_t state;
    logic is_decl;
    logic [8:0] pos;
    logic [31:0] w1_q;
    logic [31:0] w2_q;
    logic cmd_valid_q;
    logic [31:0] cmd_data_q;
    decl_t hmem [0:3][0:`DECL_SLOTS-1];

    // sanitised packet fields
    wire small_vtx = gs_enable_i && gs_vsize_zero_i;
    logic [31:0] ctrl_w1;
    logic [31:0] ctrl_w2;
    logic [15:0] mask_w;
    always_comb begin
        ctrl_w1 = 32'h0000_0000;
        ctrl_w1[`SO_EN_BIT] = so_enable_i;
        ctrl_w1[`RDIS_BIT] = render_disable_i;
        ctrl_w1[`RSEL_HI:`RSEL_LO] = render_stream_i;
        ctrl_w1[`REORD_BIT] = reorder_trailing_i;
        ctrl_w1[`STAT_BIT] = stats_enable_i;
        ctrl_w1[`BUFEN_HI:`BUFEN_LO] = buf_enable_i;
        ctrl_w2 = 32'h0000_0000;
        mask_w = 16'h0000;
        for (int s = 0; s < 4; s++) begin
            ctrl_w2[8*s + `ROFS_BIT] = small_vtx ? 1'b0 : read_offset_i[s];
            ctrl_w2[8*s +: 5] = small_vtx ? 5'h00 : read_len_i[s];
            mask_w[4*s +: 4] = (num_entries_i[s] == 8'h00) ? 4'h0 : target_mask_i[s];
        end
    end

    wire handshake = cmd_valid_q && link.cmd_ready;
    wire [8:0] last_pos = is_decl ? `DECL_LAST : `CTRL_LAST;
    wire [8:0] np = pos + 9'h001;
    wire [8:0] bidx = np - `POS_BODY;
    wire [`IDX_W-1:0] grp = bidx[7:1];
    wire [31:0] body_w = {hmem[{bidx[0], 1'b1}][grp], hmem[{bidx[0], 1'b0}][grp]};
    wire [31:0] next_w = (np == `POS_DW1) ? w1_q : ((np == `POS_DW2) ? w2_q : body_w);
    wire start = (state == hs_idle) && (send_ctrl_i || send_decl_i);

    always_ff @(posedge clk_i) begin
        if (decl_wr_i) begin
            hmem[decl_wr_stream_i][decl_wr_index_i] <= decl_wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= hs_idle;
            is_decl <= 1'b0;
            pos <= `POS_HDR;
            w1_q <= 32'h0000_0000;
            w2_q <= 32'h0000_0000;
            cmd_valid_q <= 1'b0;
            cmd_data_q <= 32'h0000_0000;
        end else if (start) begin
            state <= hs_send;
            is_decl <= send_decl_i;
            pos <= `POS_HDR;
            cmd_valid_q <= 1'b1;
            w1_q <= send_decl_i ? {16'h0000, mask_w} : ctrl_w1;
            w2_q <= send_decl_i ? num_entries_i : ctrl_w2;
            cmd_data_q <= send_decl_i ? {`OPC_DECL, 7'h00, `DECL_LEN}
                : {`OPC_CTRL, 8'h00, `CTRL_LEN};
        end else if (handshake) begin
            if (pos == last_pos) begin
                state <= hs_idle;
                cmd_valid_q <= 1'b0;
            end else begin
                pos <= np;
                cmd_data_q <= next_w;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link.prim_valid <= 1'b0;
            link.prim_stream <= 2'h0;
            link.prim_strip <= 1'b0;
            link.prim_odd <= 1'b0;
            link.prim_vcount <= '0;
            busy_o <= 1'b0;
        end else begin
            link.prim_valid <= prim_valid_i;
            link.prim_stream <= prim_stream_i;
            link.prim_strip <= prim_strip_i;
            link.prim_odd <= prim_odd_i;
            link.prim_vcount <= prim_vcount_i;
            busy_o <= start || ((state == hs_send) && !(handshake && (pos == last_pos)));
        end
    end

    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_data = cmd_data_q;
endmodule : so_command_streamer

// ==== verification/stream_output_state_decode_chk.sv ====
// checker on the command link joining streamer and decoder
// assumes it is instantiated beside the link interface in the bench
`timescale 1ns/1ns
module stream_output_state_decode_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // command link
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [31:0] cmd_data
);
    logic [8:0] pos;
    logic [8:0] len;
    logic is_decl;
    logic [15:0] mask;
    wire take = cmd_valid && cmd_ready;
    wire hdr = take && pos == 9'h000;
    wire counts = take && is_decl && pos == 9'h002;
    wire [3:0][7:0] cnt = cmd_data;
    wire [3:0][3:0] msk = mask;
    wire [3:0] bad;
    wire [3:0] big;
    for (genvar s = 0; s < 4; s++) begin : g_s
        assign bad[s] = cnt[s] == 8'h00 && msk[s] != 4'h0;
        assign big[s] = cnt[s] > 8'h80;
    end

    // tracks the dword position inside the current packet
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pos <= 9'h000;
            len <= 9'h000;
            is_decl <= 1'b0;
            mask <= 16'h0000;
        end else if (take) begin
            pos <= (pos != 9'h000 && pos == len + 9'h001) ? 9'h000 : pos + 9'h001;
            if (pos == 9'h000) begin
                len <= cmd_data[16] ? cmd_data[8:0] : {1'b0, cmd_data[7:0]};
                is_decl <= cmd_data[16];
            end
            if (pos == 9'h001) begin
                mask <= cmd_data[15:0];
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_READY_UP: assert property ($past(arst_n_i) |-> cmd_ready)
        else $error("ready low after reset");
    AST_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
        else $error("command dword dropped");
    AST_HDR_OPC: assert property (hdr |-> cmd_data[31:16] == 16'h781e || cmd_data[31:16] == 16'h7917)
        else $error("unknown header");
    AST_CTRL_LEN: assert property (hdr && !cmd_data[16] |-> cmd_data[15:0] == 16'h0001)
        else $error("control length wrong");
    AST_DECL_LEN: assert property (hdr && cmd_data[16] |-> cmd_data[15:0] == 16'h0101)
        else $error("declaration length wrong");
    AST_DECL_MASK: assert property (counts |-> bad == 4'h0)
        else $error("mask set with zero count");
    AST_DECL_COUNT: assert property (counts |-> big == 4'h0)
        else $error("count above limit");
    AST_CTRL_MBZ1: assert property (take && !is_decl && pos == 9'h001 |-> (cmd_data & 32'h21fff0ff) == 32'h0)
        else $error("reserved control bits set");
    AST_CTRL_MBZ2: assert property (take && !is_decl && pos == 9'h002 |-> (cmd_data & 32'hc0c0c0c0) == 32'h0)
        else $error("reserved size bits set");
endmodule : stream_output_state_decode_chk

// ==== verification/stream_output_state_decode_bench.sv ====
// bench joining command streamer and decoder over the link
// assumes the checker and both design ends are compiled first
`timescale 1ns/1ns
`include "so_decode_params.svh"
module stream_output_state_decode_bench;
    import so_decode_pkg::*;
    logic clk_i, arst_n_i, send_ctrl_i, so_enable_i, render_disable_i, reorder_trailing_i, stats_enable_i;
    logic gs_enable_i, gs_vsize_zero_i, decl_wr_i, send_decl_i, prim_valid_i, prim_strip_i, prim_odd_i, busy_o;
    stream_id_t render_stream_i, decl_wr_stream_i, prim_stream_i, decl_rd_stream_i, render_stream_o;
    buf_mask_t buf_enable_i, so_target_o;
    logic [3:0] read_offset_i;
    logic [3:0][4:0] read_len_i;
    logic [3:0][3:0] target_mask_i;
    logic [3:0][7:0] num_entries_i;
    logic [6:0] decl_wr_index_i, decl_rd_index_i;
    decl_t decl_wr_data_i, decl_rd_data_o;
    logic [1:0] prim_vcount_i;
    logic [3:0][31:0] buf_wr_offset_i, buf_end_i, prims_written_o, storage_needed_o, exp_w, exp_s;
    logic [3:0][11:0] buf_pitch_i;
    logic decl_rd_valid_o, render_fwd_o, so_write_o, so_overflow_o, so_read_offset_o;
    logic [5:0] so_order_o, so_read_units_o;
    decl_t ent [4][4];
    logic [6:0] q [12];
    logic [8:0] wpos = 9'h000, wlen = 9'h000;
    logic wdecl = 1'b0;
    int n_mismatch = 0, checks = 0;

    so_link_if link();
    so_command_streamer u_so_command_streamer (.clk_i, .arst_n_i, .link(link), .send_ctrl_i, .so_enable_i,
        .render_disable_i, .render_stream_i, .reorder_trailing_i, .stats_enable_i, .buf_enable_i, .read_offset_i,
        .read_len_i, .gs_enable_i, .gs_vsize_zero_i, .decl_wr_i, .decl_wr_stream_i, .decl_wr_index_i,
        .decl_wr_data_i, .send_decl_i, .target_mask_i, .num_entries_i, .prim_valid_i, .prim_stream_i,
        .prim_strip_i, .prim_odd_i, .prim_vcount_i, .busy_o);
    stream_output_state_decode u_stream_output_state_decode (.clk_i, .arst_n_i, .link(link), .buf_wr_offset_i,
        .buf_pitch_i, .buf_end_i, .decl_rd_stream_i, .decl_rd_index_i, .decl_rd_data_o, .decl_rd_valid_o,
        .render_fwd_o, .render_stream_o, .so_write_o, .so_overflow_o, .so_target_o, .so_order_o,
        .so_read_offset_o, .so_read_units_o, .prims_written_o, .storage_needed_o);
    stream_output_state_decode_chk u_stream_output_state_decode_chk (.clk_i, .arst_n_i,
        .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic send(input logic decl);
        send_decl_i = decl;
        send_ctrl_i = !decl;
        @(negedge clk_i);
        send_decl_i = 1'b0;
        send_ctrl_i = 1'b0;
        repeat (2) @(negedge clk_i);
        for (int k = 0; k < 400 && busy_o !== 1'b0; k++) @(negedge clk_i);
        repeat (3) @(negedge clk_i);
    endtask : send

    // checks the outputs caused by one primitive two cycles after it was driven
    task automatic judge(input logic [6:0] p);
        logic v, strip, odd, act, ovf, sanit;
        logic [1:0] s, vc;
        logic [3:0] m;
        {v, s, strip, odd, vc} = p;
        sanit = gs_enable_i && gs_vsize_zero_i;
        m = num_entries_i[s] == 8'h00 ? 4'h0 : target_mask_i[s];
        act = v && so_enable_i && num_entries_i[s] != 8'h00;
        ovf = 1'b0;
        for (int b = 0; b < 4; b++)
            if (m[b] && (!buf_enable_i[b] || buf_wr_offset_i[b] + vc * buf_pitch_i[b] > buf_end_i[b])) ovf = 1'b1;
        ovf = act && ovf;
        check(render_fwd_o, v && !render_disable_i && s == render_stream_i);
        if (v) check(render_stream_o, s);
        check(so_overflow_o, ovf);
        check(so_write_o, act && !ovf);
        check(so_target_o, act && !ovf ? m : 4'h0);
        check(so_order_o, strip && odd ? (reorder_trailing_i ? 6'h21 : 6'h18) : 6'h24);
        check(so_read_offset_o, sanit ? 1'b0 : read_offset_i[s]);
        check(so_read_units_o, sanit ? 6'h01 : 6'(read_len_i[s]) + 6'h01);
        if (act && stats_enable_i) begin
            exp_s[s]++;
            if (!ovf) exp_w[s]++;
        end
    endtask : judge

    task automatic run(input int it);
        {so_enable_i, render_disable_i, reorder_trailing_i, stats_enable_i, gs_enable_i, gs_vsize_zero_i} = 6'($urandom);
        {render_stream_i, buf_enable_i, read_offset_i} = 10'($urandom);
        read_len_i = 20'($urandom);
        target_mask_i = 16'($urandom);
        for (int s = 0; s < 4; s++) begin
            num_entries_i[s] = 8'($urandom_range(4, 0));
            buf_wr_offset_i[s] = $urandom_range(255, 0);
            buf_pitch_i[s] = 12'($urandom_range(63, 0));
            buf_end_i[s] = $urandom_range(400, 0);
        end
        if (it < 2) begin
            {so_enable_i, render_disable_i, stats_enable_i, buf_enable_i} = it == 0 ? 7'h55 : 7'h2f;
            target_mask_i = 16'hffff;
            num_entries_i[3] = 8'h80;
        end
        for (int i = 0; i < 16; i++) begin
            decl_wr_i = 1'b1;
            {decl_wr_stream_i, decl_wr_index_i} = {i[3:2], 5'h00, i[1:0]};
            decl_wr_data_i = 16'($urandom);
            ent[i / 4][i % 4] = decl_wr_data_i;
            @(negedge clk_i);
        end
        decl_wr_i = 1'b0;
        send(1'b1);
        send(1'b0);
        for (int i = 0; i < 16; i++) begin
            {decl_rd_stream_i, decl_rd_index_i} = {i[3:2], 5'h00, i[1:0]};
            @(negedge clk_i);
            check(decl_rd_valid_o, i % 4 < num_entries_i[i / 4]);
            check(decl_rd_data_o, i % 4 < num_entries_i[i / 4] ? ent[i / 4][i % 4] : 16'h0000);
        end
        for (int k = 0; k < 12; k++) begin
            if (k >= 2) judge(q[k - 2]);
            prim_valid_i = k < 8;
            {prim_stream_i, prim_strip_i, prim_odd_i, prim_vcount_i} = 6'($urandom);
            q[k] = {prim_valid_i, prim_stream_i, prim_strip_i, prim_odd_i, prim_vcount_i};
            @(negedge clk_i);
        end
        for (int s = 0; s < 4; s++) begin
            check(prims_written_o[s], exp_w[s]);
            check(storage_needed_o[s], exp_s[s]);
        end
        $display("test %0d done", it);
    endtask : run

    // watches the wire: body packing and sanitised stream sizes
    always @(negedge clk_i) begin
        if (!arst_n_i) wpos = 9'h000;
        else if (link.cmd_valid && link.cmd_ready) begin
            if (wdecl && wpos == 9'h003) check(link.cmd_data, {ent[1][0], ent[0][0]});
            if (!wdecl && wpos == 9'h002 && gs_enable_i && gs_vsize_zero_i) check(link.cmd_data & 32'h3f3f3f3f, 0);
            if (wpos == 9'h000) begin
                wlen = link.cmd_data[16] ? link.cmd_data[8:0] : {1'b0, link.cmd_data[7:0]};
                wdecl = link.cmd_data[16];
            end
            wpos = (wpos != 9'h000 && wpos == wlen + 9'h001) ? 9'h000 : wpos + 9'h001;
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {arst_n_i, send_ctrl_i, so_enable_i, render_disable_i, reorder_trailing_i, stats_enable_i} = '0;
        {gs_enable_i, gs_vsize_zero_i, decl_wr_i, send_decl_i, prim_valid_i, prim_strip_i, prim_odd_i} = '0;
        {render_stream_i, decl_wr_stream_i, prim_stream_i, decl_rd_stream_i, buf_enable_i, read_offset_i} = '0;
        {read_len_i, target_mask_i, num_entries_i, decl_wr_index_i, decl_rd_index_i, decl_wr_data_i} = '0;
        {prim_vcount_i, buf_wr_offset_i, buf_end_i, buf_pitch_i, exp_w, exp_s} = '0;
        void'($urandom(32'h42c5aebf));
        repeat (3) @(negedge clk_i);
        check(link.cmd_ready, 1'b0);
        check(so_order_o, 6'h24);
        arst_n_i = 1'b1;
        for (int it = 0; it < 12; it++) begin
            if (it == 6) begin
                arst_n_i = 1'b0;
                @(negedge clk_i);
                check(|{prims_written_o, storage_needed_o}, 1'b0);
                arst_n_i = 1'b1;
                {exp_w, exp_s} = '0;
            end
            run(it);
        end
        print_verdict();
    end
endmodule : stream_output_state_decode_bench
